//--- rtl/pclk_synth_params.svh
`ifndef PCLK_SYNTH_PARAMS_SVH
`define PCLK_SYNTH_PARAMS_SVH

// Increment fixed-point layout: 6 integer bits above 27 fraction bits
`define INC_W 33
`define INC_INT_W 6
`define INC_FRAC_W 27
`define INC_INT_LSB 27
`define INC_INT_MSB 32
// Accumulator width and per-cycle phase step (32 in increment units)
`define ACC_W 35
`define OSC_MULT 32
`define OSC_STEP 35'h1_0000_0000
// Valid increment window, integer part
`define INC_MIN_INT 6'h10
`define INC_MAX_INT 6'h20

// Byte register indices
`define IDX_LINE_LO 4'h0
`define IDX_LINE_HI 4'h1
`define IDX_NOM_0 4'h2
`define IDX_NOM_1 4'h3
`define IDX_NOM_2 4'h4
`define IDX_NOM_3 4'h5
`define IDX_NOM_4 4'h6
`define IDX_VCO_FEEDBACK_DIVIDER_FIELD 4'h7
`define IDX_OUT_DIV 4'h8
`define IDX_CONTROL 4'h9
`define IDX_STATUS 4'ha

// Field positions
`define CTRL_PD_OFF_BIT 0
`define STAT_LOCK_BIT 0
`define STAT_SYNC_BIT 1
`define DIV_SEL_W 3

// Reset values
`define RST_NOMINAL_INCREMENT 33'h0_ba2e_8a16
`define RST_LINE_LEN 16'h0520
`define RST_VCO_SEL 3'h3
`define RST_OUT_SEL 3'h1

// Loop behaviour
`define LOOP_GAIN_SHIFT 12
`define LOCK_TOL 17'h0_0002
`define LOCK_LINES 4'h8
`define CLK_PERIOD_NS 10
`define SYNC_TIMEOUT_NS 100000

`endif

//--- rtl/pclk_synth_pkg.sv
`default_nettype none
package pclk_synth_pkg;
    typedef logic [32:0] incr_t;
    typedef logic [15:0] line_len_t;
    typedef logic [2:0] div_sel_t;
    typedef enum logic [1:0] {SEARCH, LOCKED} lock_e;
endpackage : pclk_synth_pkg
`default_nettype wire

//--- rtl/incr_osc_if.sv
`default_nettype none
// Working increment out to the oscillator, wrap count back
interface incr_osc_if;
    logic [32:0] workInc;
    logic [1:0] dtoTicks;
    modport ctrl (output workInc, input dtoTicks);
    modport osc (input workInc, output dtoTicks);
endinterface : incr_osc_if
`default_nettype wire

//--- rtl/increment_oscillator.sv
`include "pclk_synth_params.svh"
`default_nettype none
module increment_oscillator (
    input wire logic ref_clk, // Reference clock
    input wire logic reset_n, // Async reset, active low
    incr_osc_if.osc link // Increment in, ticks out
);
    import pclk_synth_pkg::*;

    logic [`ACC_W-1:0] phase_reg;
    logic [`ACC_W-1:0] sum;
    logic [`ACC_W-1:0] incWide;
    logic [`ACC_W-1:0] afterOne;
    logic [`ACC_W-1:0] phase_next;
    logic [1:0] ticks;

    // Add 32 each cycle, subtract increment per wrap: rate 32*f/inc
    always_comb
    begin
        incWide = {2'b00, link.workInc};
        sum = phase_reg + `OSC_STEP;
        afterOne = sum;
        ticks = 2'd0;
        phase_next = sum;
        if (incWide != '0 && sum >= incWide)
        begin
            afterOne = sum - incWide;
            ticks = 2'd1;
            phase_next = afterOne;
            if (afterOne >= incWide)
            begin
                phase_next = afterOne - incWide;
                ticks = 2'd2;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_reg <= '0;
        else
            phase_reg <= phase_next;
    end

    assign link.dtoTicks = ticks;

    // Ticks follow the fixed step against the increment
    a_tick_rate_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (link.workInc[`INC_INT_MSB:`INC_INT_LSB] >= `INC_MIN_INT && phase_reg < incWide)
        |-> (phase_next < incWide))
        else $error("oscillator dropped a wrap");
endmodule : increment_oscillator
`default_nettype wire

//--- rtl/line_locked_pixel_clock_synth.sv
// Functional notes
// - The oscillator runs at thirty-two times the reference rate over the working increment.
// - The synthesized clock is the oscillator output divided by the output clock divider.
// - Nominal and working increments are 33-bit unsigned, 6 integer over 27 fraction bits.
// - An increment reads as the top six bits plus the low 27 bits times two to the -27.
// - The integer bits sit directly above the fraction bits in one 33-bit value.
// - Writing the nominal increment reloads the working increment with it.
// - With the phase detector off the working increment stays at nominal.
// - The register port runs from the reference clock and refuses transfers while the working increment is outside 16..32.
`include "pclk_synth_params.svh"
`default_nettype none
module line_locked_pixel_clock_synth #(
    parameter int SYNC_TIMEOUT_CYC = `SYNC_TIMEOUT_NS / `CLK_PERIOD_NS
) (
    input wire logic ref_clk, // Reference clock, 100 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic hsync, // Horizontal sync, active high
    input wire logic regWrite, // Byte write request
    input wire logic regRead, // Byte read request
    input wire logic [3:0] regIndex, // Byte register index
    input wire logic [7:0] regWrData, // Write data
    output logic [7:0] regRdData, // Read data, registered
    output logic regAck, // Transfer acknowledged
    output logic synthClkOut, // Synthesized clock level
    output logic [1:0] synthClkCycles, // Output cycles this ref cycle
    output logic lockDetect, // Loop locked
    output logic syncDetect, // Sync present
    output pclk_synth_pkg::div_sel_t vcoFeedbackDividerField, // To analog loop
    output pclk_synth_pkg::incr_t workingIncrement // Live increment
);
    import pclk_synth_pkg::*;

    incr_osc_if link ();
    increment_oscillator osc (.ref_clk(ref_clk), .reset_n(reset_n), .link(link));

    incr_t nominalIncrement_reg;
    incr_t workInc_reg;
    incr_t workInc_next;
    line_len_t lineLen_reg;
    div_sel_t vcoSel_reg;
    div_sel_t outSel_reg;
    logic pdOff_reg;
    logic [7:0] divCnt_reg;
    logic [7:0] divCnt_next;
    logic [1:0] outCyc_next;
    logic [1:0] outCyc_reg;
    logic clkLevel_reg;
    line_len_t lineCnt_reg;
    logic hsyncPrev_reg;
    logic hsEdge;
    logic signed [16:0] phaseErr;
    logic [16:0] errMag;
    lock_e lockState_reg;
    logic [3:0] goodLines_reg;
    logic [31:0] syncTimer_reg;
    logic syncSeen_reg;
    logic oscValid;
    logic access;

    // Ratio from base-two field
    function automatic logic [7:0] ratio_of(input div_sel_t sel);
        ratio_of = 8'h01 << sel;
    endfunction : ratio_of

    // Integer part of a 6.27 increment
    function automatic logic [5:0] int_part(input incr_t v);
        int_part = v[`INC_INT_MSB:`INC_INT_LSB];
    endfunction : int_part

    // Oscillator is stable only inside the valid increment window
    assign oscValid = int_part(workInc_reg) >= `INC_MIN_INT &&
        (int_part(workInc_reg) < `INC_MAX_INT ||
        workInc_reg == {`INC_MAX_INT, {`INC_FRAC_W{1'b0}}});
    assign access = regWrite || regRead;
    assign regAck = access && oscValid;

    // Host byte registers, dropped when the port is dead
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nominalIncrement_reg <= `RST_NOMINAL_INCREMENT;
            lineLen_reg <= `RST_LINE_LEN;
            vcoSel_reg <= `RST_VCO_SEL;
            outSel_reg <= `RST_OUT_SEL;
            pdOff_reg <= 1'b0;
        end
        else if (regWrite && oscValid)
        begin
            unique case (regIndex)
                `IDX_LINE_LO: lineLen_reg[7:0] <= regWrData;
                `IDX_LINE_HI: lineLen_reg[15:8] <= regWrData;
                `IDX_NOM_0: nominalIncrement_reg[7:0] <= regWrData;
                `IDX_NOM_1: nominalIncrement_reg[15:8] <= regWrData;
                `IDX_NOM_2: nominalIncrement_reg[23:16] <= regWrData;
                `IDX_NOM_3: nominalIncrement_reg[31:24] <= regWrData;
                `IDX_NOM_4: nominalIncrement_reg[32] <= regWrData[0];
                `IDX_VCO_FEEDBACK_DIVIDER_FIELD: vcoSel_reg <= regWrData[2:0];
                `IDX_OUT_DIV: outSel_reg <= regWrData[2:0];
                `IDX_CONTROL: pdOff_reg <= regWrData[`CTRL_PD_OFF_BIT];
                default: ;
            endcase
        end
    end

    // Read data captured on an acknowledged read
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            regRdData <= 8'h00;
        else if (regRead && oscValid)
        begin
            unique case (regIndex)
                `IDX_LINE_LO: regRdData <= lineLen_reg[7:0];
                `IDX_LINE_HI: regRdData <= lineLen_reg[15:8];
                `IDX_NOM_0: regRdData <= nominalIncrement_reg[7:0];
                `IDX_NOM_1: regRdData <= nominalIncrement_reg[15:8];
                `IDX_NOM_2: regRdData <= nominalIncrement_reg[23:16];
                `IDX_NOM_3: regRdData <= nominalIncrement_reg[31:24];
                `IDX_NOM_4: regRdData <= {7'h00, nominalIncrement_reg[32]};
                `IDX_VCO_FEEDBACK_DIVIDER_FIELD: regRdData <= {5'h00, vcoSel_reg};
                `IDX_OUT_DIV: regRdData <= {5'h00, outSel_reg};
                `IDX_CONTROL: regRdData <= {7'h00, pdOff_reg};
                `IDX_STATUS: regRdData <= {6'h00, syncSeen_reg, lockDetect};
                default: regRdData <= 8'h00;
            endcase
        end
    end

    // Sync edge and phase error against programmed line length
    assign hsEdge = hsync && !hsyncPrev_reg;
    assign phaseErr = $signed({1'b0, lineCnt_reg}) - $signed({1'b0, lineLen_reg});
    assign errMag = phaseErr[16] ? 17'(-phaseErr) : 17'(phaseErr);

    // Working increment: reload, hold, or trim by the phase error
    always_comb
    begin
        workInc_next = workInc_reg;
        if (regWrite && oscValid && regIndex >= `IDX_NOM_0 && regIndex <= `IDX_NOM_4)
        begin
            workInc_next = nominalIncrement_reg;
            unique case (regIndex)
                `IDX_NOM_0: workInc_next[7:0] = regWrData;
                `IDX_NOM_1: workInc_next[15:8] = regWrData;
                `IDX_NOM_2: workInc_next[23:16] = regWrData;
                `IDX_NOM_3: workInc_next[31:24] = regWrData;
                default: workInc_next[32] = regWrData[0];
            endcase
        end
        else if (pdOff_reg)
            workInc_next = nominalIncrement_reg;
        else if (hsEdge)
            workInc_next = 33'(workInc_reg + 33'(signed'(phaseErr) <<< `LOOP_GAIN_SHIFT));
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            workInc_reg <= `RST_NOMINAL_INCREMENT;
        else
            workInc_reg <= workInc_next;
    end

    assign link.workInc = workInc_reg;
    assign workingIncrement = workInc_reg;
    assign vcoFeedbackDividerField = vcoSel_reg;

    // Output divider: count oscillator ticks, wrap at the ratio
    always_comb
    begin
        divCnt_next = divCnt_reg + {6'h00, link.dtoTicks};
        // Count left over from a larger ratio restarts, else it never drains
        if (divCnt_reg >= ratio_of(outSel_reg))
            divCnt_next = {6'h00, link.dtoTicks};
        outCyc_next = 2'd0;
        if (divCnt_next >= ratio_of(outSel_reg))
        begin
            divCnt_next = divCnt_next - ratio_of(outSel_reg);
            outCyc_next = 2'd1;
            if (divCnt_next >= ratio_of(outSel_reg))
            begin
                divCnt_next = divCnt_next - ratio_of(outSel_reg);
                outCyc_next = 2'd2;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_reg <= 8'h00;
            outCyc_reg <= 2'd0;
            clkLevel_reg <= 1'b0;
        end
        else
        begin
            divCnt_reg <= divCnt_next;
            outCyc_reg <= outCyc_next;
            clkLevel_reg <= {divCnt_next, 1'b0} < {1'b0, ratio_of(outSel_reg)};
        end
    end

    assign synthClkCycles = outCyc_reg;
    assign synthClkOut = clkLevel_reg;

    // Feedback counter of output cycles per sync period
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hsyncPrev_reg <= 1'b0;
            lineCnt_reg <= '0;
        end
        else
        begin
            hsyncPrev_reg <= hsync;
            if (hsEdge)
                lineCnt_reg <= {14'h0000, outCyc_reg};
            else
                lineCnt_reg <= 16'(lineCnt_reg + {14'h0000, outCyc_reg});
        end
    end

    // Lock: enough consecutive lines within tolerance
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lockState_reg <= SEARCH;
            goodLines_reg <= 4'h0;
        end
        else if (pdOff_reg || !syncSeen_reg)
        begin
            lockState_reg <= SEARCH;
            goodLines_reg <= 4'h0;
        end
        else if (hsEdge)
        begin
            unique case (lockState_reg)
                SEARCH:
                begin
                    goodLines_reg <= errMag <= `LOCK_TOL ? goodLines_reg + 4'h1 : 4'h0;
                    if (errMag <= `LOCK_TOL && goodLines_reg + 4'h1 >= `LOCK_LINES)
                        lockState_reg <= LOCKED;
                end
                LOCKED:
                    if (errMag > `LOCK_TOL)
                    begin
                        lockState_reg <= SEARCH;
                        goodLines_reg <= 4'h0;
                    end
            endcase
        end
    end

    assign lockDetect = lockState_reg == LOCKED;

    // Sync presence: timer since last edge
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncTimer_reg <= '0;
            syncSeen_reg <= 1'b0;
        end
        else if (hsEdge)
        begin
            syncTimer_reg <= '0;
            syncSeen_reg <= 1'b1;
        end
        else if (syncTimer_reg >= 32'(SYNC_TIMEOUT_CYC))
            syncSeen_reg <= 1'b0;
        else
            syncTimer_reg <= syncTimer_reg + 32'd1;
    end

    assign syncDetect = syncSeen_reg;

    sequence s_nom_write;
        regWrite && oscValid && regIndex == `IDX_NOM_0;
    endsequence

    a_nominal_reload: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_nom_write |=> workInc_reg == nominalIncrement_reg)
        else $error("working increment not reloaded");
    a_pd_off_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pdOff_reg && !regWrite ##1 pdOff_reg |-> workInc_reg == $past(nominalIncrement_reg))
        else $error("increment moved with detector off");
    a_dead_no_ack: assert property (@(posedge ref_clk) disable iff (!reset_n)
        access && !oscValid |-> !regAck)
        else $error("ack given without stable clock");
    a_dead_no_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWrite && !oscValid && regIndex == `IDX_LINE_LO |=> $stable(lineLen_reg))
        else $error("write stored without stable clock");
    a_div_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
        divCnt_reg < ratio_of(outSel_reg) || $changed(outSel_reg))
        else $error("divider counter overran ratio");
    a_locked_exact: assert property (@(posedge ref_clk) disable iff (!reset_n)
        lockDetect && hsEdge && !pdOff_reg |-> (errMag <= `LOCK_TOL) or (##1 !lockDetect))
        else $error("lock held with bad line count");
    a_byte_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regWrite && oscValid && regIndex == `IDX_LINE_HI |=>
        lineLen_reg[15:8] == $past(regWrData) && $stable(lineLen_reg[7:0]))
        else $error("line length high byte misplaced");
    a_read_vco: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regRead && oscValid && regIndex == `IDX_VCO_FEEDBACK_DIVIDER_FIELD |=>
        regRdData == {5'h00, $past(vcoSel_reg)})
        else $error("divider field readback wrong");
endmodule : line_locked_pixel_clock_synth
`default_nettype wire

//--- bench/hsync_source.sv
`default_nettype none
// Video source model: periodic horizontal sync, held low while switched off
module hsync_source (
    input wire logic ref_clk, // Reference clock
    input wire logic reset_n, // Async reset, active low
    input wire logic enable, // Emit sync pulses
    input wire logic [15:0] period, // Line time in ref cycles
    output logic hsync // Horizontal sync, active high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lineCnt;
    // Line timer, restarts whenever the source is switched off
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            lineCnt <= 16'h0000;
        else if (!enable || lineCnt == period - 16'h0001)
            lineCnt <= 16'h0000;
        else
            lineCnt <= lineCnt + 16'h0001;
    end
    // Two-cycle sync pulse at the start of every line
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            hsync <= 1'b0;
        else
            hsync <= enable && (lineCnt < 16'h0002);
    end
endmodule : hsync_source
`default_nettype wire

//--- bench/line_locked_pixel_clock_synth_tb_top.sv
`include "pclk_synth_params.svh"
`default_nettype none
module line_locked_pixel_clock_synth_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pclk_synth_pkg::*;
    localparam int SYNC_TO = 300;
    localparam incr_t NOM16 = 33'h0_8000_0000;
    localparam incr_t NOMRST = 33'h0_ba2e_8a16;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [3:0] regIndex = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic srcEnable = 1'b0;
    logic [15:0] srcPeriod = 16'h00c8;
    logic [7:0] regRdData;
    logic regAck, synthClkOut, lockDetect, syncDetect, hsync;
    logic [1:0] synthClkCycles;
    div_sel_t vcoFeedbackDividerField;
    incr_t workingIncrement, nomModel;
    int err_count = 0;
    int n_checks = 0;
    int cycleCount = 0;
    // Reset contents: index in the top nibble, value below
    logic [11:0] rstRows [13] = '{12'h020, 12'h105, 12'h216, 12'h38a, 12'h42e, 12'h5ba,
        12'h600, 12'h703, 12'h801, 12'h900, 12'ha00, 12'hb00, 12'hf00};
    // Oscillator rows: nominal increment and output divider select
    typedef struct {incr_t nom; div_sel_t sel;} osc_row_s;
    osc_row_s oscRows [5] = '{'{NOM16, 3'h0}, '{NOM16, 3'h1}, '{NOM16, 3'h2},
        '{NOM16, 3'h3}, '{NOMRST, 3'h0}};

    line_locked_pixel_clock_synth #(.SYNC_TIMEOUT_CYC(SYNC_TO)) line_locked_pixel_clock_synth_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsync(hsync), .regWrite(regWrite),
        .regRead(regRead), .regIndex(regIndex), .regWrData(regWrData),
        .regRdData(regRdData), .regAck(regAck), .synthClkOut(synthClkOut),
        .synthClkCycles(synthClkCycles), .lockDetect(lockDetect), .syncDetect(syncDetect),
        .vcoFeedbackDividerField(vcoFeedbackDividerField),
        .workingIncrement(workingIncrement));
    hsync_source hsync_source_i (.ref_clk(ref_clk), .reset_n(reset_n), .enable(srcEnable),
        .period(srcPeriod), .hsync(hsync));

    // Free-running reference clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            err_count++;
            $display("wrong value at %0t: run did not finish in time", $time);
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Exact comparison of design values
    task automatic chk_eq(input logic [32:0] got, input logic [32:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_eq
    // Clock counts compared with a small phase allowance
    task automatic chk_near(input longint got, input longint exp, input string what);
        n_checks++;
        if (got < exp - 2 || got > exp + 2)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_near
    // One register transfer, request held for exactly one edge
    task automatic reg_xfer(input logic wr, input logic [3:0] idx, input logic [7:0] data,
        output logic [7:0] rd, output logic ack);
        @(posedge ref_clk);
        regWrite <= wr;
        regRead <= !wr;
        regIndex <= idx;
        regWrData <= data;
        @(negedge ref_clk);
        ack = regAck;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        @(negedge ref_clk);
        rd = regRdData;
    endtask : reg_xfer
    // Host loads a nominal increment byte by byte, staying inside 16..32
    task automatic set_nom(input incr_t n);
        logic [7:0] rd;
        logic ack;
        int order [5] = '{3, 2, 1, 0, 4};
        foreach (order[k])
        begin
            nomModel[order[k] * 8 +: 8] = n[order[k] * 8 +: 8];
            reg_xfer(1'b1, `IDX_NOM_0 + 4'(order[k]), 8'(n >> (order[k] * 8)), rd, ack);
            chk_eq(ack, 1'b1, "nominal write ack");
            chk_eq(workingIncrement, nomModel, "working after nominal byte");
        end
    endtask : set_nom
    // Sum of synthesized clock cycles and high clock levels over a number of ref cycles
    task automatic count_clk(input int cycles, output longint sum, output longint hiCnt);
        sum = 0;
        hiCnt = 0;
        repeat (cycles)
        begin
            @(negedge ref_clk);
            sum += synthClkCycles;
            hiCnt += synthClkOut;
        end
    endtask : count_clk

    // Main sequence
    initial
    begin
        logic [7:0] rd;
        logic ack;
        longint sum;
        longint hiCnt;
        nomModel = NOMRST;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk_eq(workingIncrement, NOMRST, "working at reset");
        chk_eq(vcoFeedbackDividerField, 3'h3, "vco field at reset");
        foreach (rstRows[i])
        begin
            reg_xfer(1'b0, rstRows[i][11:8], 8'h00, rd, ack);
            chk_eq(rd, rstRows[i][7:0], "reset register");
        end
        foreach (oscRows[i])
        begin
            set_nom(oscRows[i].nom);
            reg_xfer(1'b1, `IDX_OUT_DIV, 8'(oscRows[i].sel), rd, ack);
            repeat (4) @(posedge ref_clk);
            count_clk(400, sum, hiCnt);
            chk_near(sum, ((64'd400 << 32) / oscRows[i].nom) >> oscRows[i].sel,
                "synth cycles");
            chk_near(hiCnt, oscRows[i].sel >= 3'h2 ? 200 : 400, "clock high cycles");
        end
        // Sync lock: 200 pixel clocks per 200-cycle line
        set_nom(NOM16);
        reg_xfer(1'b1, `IDX_OUT_DIV, 8'h01, rd, ack);
        reg_xfer(1'b1, `IDX_LINE_LO, 8'hc8, rd, ack);
        reg_xfer(1'b1, `IDX_LINE_HI, 8'h00, rd, ack);
        reg_xfer(1'b1, `IDX_CONTROL, 8'h01, rd, ack);
        @(posedge ref_clk);
        srcEnable <= 1'b1;
        repeat (400) @(posedge ref_clk);
        reg_xfer(1'b1, `IDX_CONTROL, 8'h00, rd, ack);
        repeat (2200) @(posedge ref_clk);
        chk_eq(lockDetect, 1'b1, "lock");
        chk_eq(syncDetect, 1'b1, "sync present");
        chk_eq(workingIncrement, NOM16, "working with zero error");
        @(posedge hsync);
        count_clk(200, sum, hiCnt);
        chk_near(sum, 200, "cycles per line");
        // Line length one below the count: trim up by one count at gain 2^12, stays above 16
        @(posedge hsync);
        reg_xfer(1'b1, `IDX_LINE_LO, 8'hc7, rd, ack);
        @(posedge hsync);
        repeat (3) @(negedge ref_clk);
        chk_eq(workingIncrement, NOM16 + 33'h0_0000_1000, "trimmed working");
        reg_xfer(1'b1, `IDX_CONTROL, 8'h01, rd, ack);
        repeat (2) @(negedge ref_clk);
        chk_eq(workingIncrement, NOM16, "working with detector off");
        chk_eq(lockDetect, 1'b0, "lock with detector off");
        @(posedge ref_clk);
        srcEnable <= 1'b0;
        repeat (SYNC_TO + 10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_eq(syncDetect, 1'b0, "sync lost");
        reg_xfer(1'b1, `IDX_VCO_FEEDBACK_DIVIDER_FIELD, 8'h02, rd, ack);
        @(negedge ref_clk);
        chk_eq(vcoFeedbackDividerField, 3'h2, "vco field");
        reg_xfer(1'b1, 4'hb, 8'hff, rd, ack);
        reg_xfer(1'b0, 4'hb, 8'h00, rd, ack);
        chk_eq(rd, 8'h00, "unmapped read");
        // Increment pushed above 32: port stops answering until reset
        reg_xfer(1'b1, `IDX_NOM_4, 8'h01, rd, ack);
        chk_eq(workingIncrement, 33'h1_8000_0000, "out of range working");
        reg_xfer(1'b0, `IDX_LINE_LO, 8'h00, rd, ack);
        chk_eq(ack, 1'b0, "ack without valid clock");
        reg_xfer(1'b1, `IDX_LINE_LO, 8'h55, rd, ack);
        chk_eq(ack, 1'b0, "write ack without valid clock");
        reg_xfer(1'b1, `IDX_NOM_4, 8'h00, rd, ack);
        chk_eq(workingIncrement, 33'h1_8000_0000, "dead write stored");
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_xfer(1'b0, `IDX_LINE_LO, 8'h00, rd, ack);
        chk_eq(ack, 1'b1, "ack after reset");
        chk_eq(rd, 8'h20, "line low after reset");
        chk_eq(workingIncrement, NOMRST, "working after reset");
        stop_test();
    end
endmodule : line_locked_pixel_clock_synth_tb_top
`default_nettype wire
